// File: common/dbs_ctl_defs.vh
`ifndef DBS_CTL_DEFS_VH
`define DBS_CTL_DEFS_VH

// Register byte offsets
`define DBS_OFS_COMMAND 8'h00
`define DBS_OFS_SETUP 8'h04
`define DBS_OFS_IRQ_SET 8'h08
`define DBS_OFS_IRQ_CLR 8'h0C
`define DBS_OFS_IRQ_VIEW 8'h10
`define DBS_OFS_FLAGS 8'h14

// Command register bit positions
`define DBS_CMD_RX_RESET 2
`define DBS_CMD_TX_RESET 3
`define DBS_CMD_RX_ON 4
`define DBS_CMD_RX_OFF 5
`define DBS_CMD_TX_ON 6
`define DBS_CMD_TX_OFF 7
`define DBS_CMD_ERR_CLR 8

// Line setup register fields
`define DBS_SETUP_PAR_LSB 9
`define DBS_SETUP_PAR_MSB 11
`define DBS_SETUP_CHM_LSB 14
`define DBS_SETUP_CHM_MSB 15
`define DBS_SETUP_MASK 32'h0000_CE00
`define DBS_SETUP_RESET 32'h0000_0000

// Shared bit map of flags and interrupt masks
`define DBS_BIT_RX_READY 0
`define DBS_BIT_TX_READY 1
`define DBS_BIT_RX_END 3
`define DBS_BIT_TX_END 4
`define DBS_BIT_OVERRUN 5
`define DBS_BIT_FRAMING 6
`define DBS_BIT_CHECK 7
`define DBS_BIT_TX_IDLE 9
`define DBS_BIT_TX_BUF_EMPTY 11
`define DBS_BIT_RX_BUF_FULL 12
`define DBS_BIT_DBG_WRITE 30
`define DBS_BIT_DBG_READ 31
`define DBS_FLAG_MASK 32'hC000_1AFB
`define DBS_IRQ_RESET 32'h0000_0000

// Channel test select codes
`define DBS_CHM_NORMAL 2'b00
`define DBS_CHM_ECHO 2'b01
`define DBS_CHM_LOCAL 2'b10
`define DBS_CHM_REMOTE 2'b11

// Check bit kinds handed to the shift engines
`define DBS_PAR_EVEN 2'b00
`define DBS_PAR_ODD 2'b01
`define DBS_PAR_ZERO 2'b10
`define DBS_PAR_ONE 2'b11

`endif

// File: design/dbs_ctl.v
// Summary of operation
// - Receiver reset command aborts and disables receiver
// - Transmitter reset command aborts and disables transmitter
// - Receiver on command works unless receiver off or receiver reset
// - Receiver off waits for current character
// - Transmitter on command works unless transmitter off or transmitter reset
// - Transmitter off waits for shift and holding
// - Error clear command clears three error flags
// - Check bit type selects parity kind
// - Irq set enable writes set mask bits
// - Irq clear enable writes clear mask bits
// - Irq enabled view reads the mask
// - All flag registers share one bit map
// - Receive ready needs unread character and enable
// - Transmit ready: holding empty and enabled
// - Block end flags mirror channel end signals
// - Transmit buffer empty mirrors channel signal
// - Receive buffer full mirrors channel signal
// - Error flags sticky until error clear command
// - Transmitter idle: holding and shifter empty and enabled
// - Top two flags mirror debug pending signals
// - Echo mode retransmits input, transmitter ignored
// - Local loopback feeds transmitter to receiver
// - Remote loopback ties input to output
`timescale 1ns/1ps
`include "dbs_ctl_defs.vh"

module dbs_ctl #(
   parameter ADDR_W = 8
) (
   input wire clock,
   input wire reset,
   input wire [ADDR_W-1:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0] avs_byteenable,
   output reg [31:0] avs_readdata,
   output wire avs_waitrequest,
   input wire rx_char_waiting,
   input wire rx_busy,
   input wire tx_holding_full,
   input wire tx_busy,
   input wire overrun_event,
   input wire framing_event,
   input wire check_bit_event,
   input wire rx_block_end,
   input wire tx_block_end,
   input wire tx_block_buf_empty,
   input wire rx_block_buf_full,
   input wire debug_write_pending,
   input wire debug_read_pending,
   input wire tx_line,
   input wire serial_in_pin,
   output reg rx_line,
   output reg serial_out_pin,
   output reg rx_abort,
   output reg tx_abort,
   output reg rx_run,
   output reg tx_run,
   output reg parity_on,
   output reg [1:0] parity_kind,
   output reg irq
);

   // Decode a check bit type code into {enable, kind}
   function [2:0] par_decode;
      input [2:0] code;
      begin
         if (code[2]) begin
            par_decode = {1'b0, `DBS_PAR_EVEN};
         end else begin
            par_decode = {1'b1, code[1:0]};
         end
      end
   endfunction

   // Byte lane mask from Avalon byte enables
   function [31:0] lane_mask;
      input [3:0] be;
      begin
         lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      end
   endfunction

   reg ack_q;
   reg [31:0] setup_q;
   reg [31:0] mask_q;
   reg rx_en_q;
   reg tx_en_q;
   reg rx_off_pend_q;
   reg tx_off_pend_q;
   reg ovr_q;
   reg frm_q;
   reg chk_q;
   reg in_meta_q;
   reg in_sync_q;
   reg dw_meta_q;
   reg dw_sync_q;
   reg dr_meta_q;
   reg dr_sync_q;

   wire [31:0] wdata;
   wire wr_go;
   wire rd_go;
   wire cmd_wr;
   wire [1:0] chm;
   wire remote;
   wire rx_live;
   wire tx_live;
   wire clr_err;
   wire tx_drained;
   reg [31:0] flags;
   reg [31:0] rd_mux;

   // One wait state: request seen, answer on the next cycle
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
   assign wr_go = avs_write & ack_q;
   assign rd_go = avs_read & ~ack_q;
   assign wdata = avs_writedata & lane_mask(avs_byteenable);
   assign cmd_wr = wr_go & (avs_address == `DBS_OFS_COMMAND);
   assign clr_err = cmd_wr & wdata[`DBS_CMD_ERR_CLR];
   assign chm = setup_q[`DBS_SETUP_CHM_MSB:`DBS_SETUP_CHM_LSB];
   // Engines idle in remote loopback
   assign remote = (chm == `DBS_CHM_REMOTE);
   assign rx_live = rx_en_q & ~remote;
   assign tx_live = tx_en_q & ~remote;
   assign tx_drained = ~tx_busy & ~tx_holding_full;

   always @(posedge clock) begin
      if (reset) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= (avs_read | avs_write) & ~ack_q;
      end
   end

   // Receiver enable state
   always @(posedge clock) begin
      if (reset) begin
         rx_en_q <= 1'b0;
         rx_off_pend_q <= 1'b0;
         rx_abort <= 1'b0;
      end else begin
         rx_abort <= cmd_wr & wdata[`DBS_CMD_RX_RESET];
         if (cmd_wr & wdata[`DBS_CMD_RX_RESET]) begin
            rx_en_q <= 1'b0;
            rx_off_pend_q <= 1'b0;
         end else if (cmd_wr & wdata[`DBS_CMD_RX_OFF]) begin
            // Let a character in flight finish first
            if (rx_busy) begin
               rx_off_pend_q <= 1'b1;
            end else begin
               rx_en_q <= 1'b0;
               rx_off_pend_q <= 1'b0;
            end
         end else if (cmd_wr & wdata[`DBS_CMD_RX_ON]) begin
            rx_en_q <= 1'b1;
            rx_off_pend_q <= 1'b0;
         end else if (rx_off_pend_q & ~rx_busy) begin
            rx_en_q <= 1'b0;
            rx_off_pend_q <= 1'b0;
         end
      end
   end

   // Transmitter enable state
   always @(posedge clock) begin
      if (reset) begin
         tx_en_q <= 1'b0;
         tx_off_pend_q <= 1'b0;
         tx_abort <= 1'b0;
      end else begin
         tx_abort <= cmd_wr & wdata[`DBS_CMD_TX_RESET];
         if (cmd_wr & wdata[`DBS_CMD_TX_RESET]) begin
            tx_en_q <= 1'b0;
            tx_off_pend_q <= 1'b0;
         end else if (cmd_wr & wdata[`DBS_CMD_TX_OFF]) begin
            // Shifting and held characters both go out first
            if (!tx_drained) begin
               tx_off_pend_q <= 1'b1;
            end else begin
               tx_en_q <= 1'b0;
               tx_off_pend_q <= 1'b0;
            end
         end else if (cmd_wr & wdata[`DBS_CMD_TX_ON]) begin
            tx_en_q <= 1'b1;
            tx_off_pend_q <= 1'b0;
         end else if (tx_off_pend_q & tx_drained) begin
            tx_en_q <= 1'b0;
            tx_off_pend_q <= 1'b0;
         end
      end
   end

   // Line setup and interrupt mask
   always @(posedge clock) begin
      if (reset) begin
         setup_q <= `DBS_SETUP_RESET;
         mask_q <= `DBS_IRQ_RESET;
      end else if (wr_go) begin
         if (avs_address == `DBS_OFS_SETUP) begin
            setup_q <= (setup_q & ~lane_mask(avs_byteenable))
               | (wdata & `DBS_SETUP_MASK);
         end
         if (avs_address == `DBS_OFS_IRQ_SET) begin
            mask_q <= mask_q | (wdata & `DBS_FLAG_MASK);
         end
         if (avs_address == `DBS_OFS_IRQ_CLR) begin
            mask_q <= mask_q & ~wdata;
         end
      end
   end

   // Sticky errors; a new error beats a same-cycle clear
   always @(posedge clock) begin
      if (reset) begin
         ovr_q <= 1'b0;
         frm_q <= 1'b0;
         chk_q <= 1'b0;
      end else begin
         ovr_q <= overrun_event | (ovr_q & ~clr_err);
         frm_q <= framing_event | (frm_q & ~clr_err);
         chk_q <= check_bit_event | (chk_q & ~clr_err);
      end
   end

   // Pin and processor-domain inputs pass two flops
   always @(posedge clock) begin
      if (reset) begin
         in_meta_q <= 1'b1;
         in_sync_q <= 1'b1;
         dw_meta_q <= 1'b0;
         dw_sync_q <= 1'b0;
         dr_meta_q <= 1'b0;
         dr_sync_q <= 1'b0;
      end else begin
         in_meta_q <= serial_in_pin;
         in_sync_q <= in_meta_q;
         dw_meta_q <= debug_write_pending;
         dw_sync_q <= dw_meta_q;
         dr_meta_q <= debug_read_pending;
         dr_sync_q <= dr_meta_q;
      end
   end

   always @* begin
      flags = 32'h0000_0000;
      flags[`DBS_BIT_RX_READY] = rx_char_waiting & rx_live;
      flags[`DBS_BIT_TX_READY] = ~tx_holding_full & tx_live;
      flags[`DBS_BIT_RX_END] = rx_block_end;
      flags[`DBS_BIT_TX_END] = tx_block_end;
      flags[`DBS_BIT_OVERRUN] = ovr_q;
      flags[`DBS_BIT_FRAMING] = frm_q;
      flags[`DBS_BIT_CHECK] = chk_q;
      flags[`DBS_BIT_TX_IDLE] = tx_drained & tx_live;
      flags[`DBS_BIT_TX_BUF_EMPTY] = tx_block_buf_empty;
      flags[`DBS_BIT_RX_BUF_FULL] = rx_block_buf_full;
      flags[`DBS_BIT_DBG_WRITE] = dw_sync_q;
      flags[`DBS_BIT_DBG_READ] = dr_sync_q;
   end

   always @* begin
      case (avs_address)
         `DBS_OFS_SETUP: rd_mux = setup_q & `DBS_SETUP_MASK;
         `DBS_OFS_IRQ_VIEW: rd_mux = mask_q;
         `DBS_OFS_FLAGS: rd_mux = flags;
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // Read data is captured on the request edge and holds until the next read
   always @(posedge clock) begin
      if (reset) begin
         avs_readdata <= 32'h0000_0000;
      end else if (rd_go) begin
         avs_readdata <= rd_mux;
      end
   end

   // Serial routing by channel test select
   always @(posedge clock) begin
      if (reset) begin
         serial_out_pin <= 1'b1;
         rx_line <= 1'b1;
      end else begin
         case (chm)
            `DBS_CHM_ECHO: begin
               serial_out_pin <= in_sync_q;
               rx_line <= in_sync_q;
            end
            `DBS_CHM_LOCAL: begin
               serial_out_pin <= 1'b1;
               rx_line <= tx_line;
            end
            `DBS_CHM_REMOTE: begin
               serial_out_pin <= in_sync_q;
               rx_line <= 1'b1;
            end
            default: begin
               serial_out_pin <= tx_line;
               rx_line <= in_sync_q;
            end
         endcase
      end
   end

   // Engine controls and interrupt line
   always @(posedge clock) begin
      if (reset) begin
         rx_run <= 1'b0;
         tx_run <= 1'b0;
         parity_on <= 1'b0;
         parity_kind <= `DBS_PAR_EVEN;
         irq <= 1'b0;
      end else begin
         rx_run <= rx_live;
         tx_run <= tx_live;
         {parity_on, parity_kind} <=
            par_decode(setup_q[`DBS_SETUP_PAR_MSB:`DBS_SETUP_PAR_LSB]);
         irq <= |(flags & mask_q);
      end
   end

endmodule

// File: verif/dbs_ctl_checker.sv
`timescale 1ns/1ps
`include "dbs_ctl_defs.vh"
module dbs_ctl_checker #(
   parameter ADDR_W = 8
) (
   input wire clock,
   input wire reset,
   input wire [ADDR_W-1:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0] avs_byteenable,
   input wire [31:0] avs_readdata,
   input wire avs_waitrequest,
   input wire rx_busy,
   input wire rx_block_end,
   input wire tx_block_end,
   input wire rx_abort,
   input wire tx_abort,
   input wire rx_run,
   input wire parity_on,
   input wire [1:0] parity_kind
);
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   wire wr_cmd = avs_write && !avs_waitrequest && avs_address == `DBS_OFS_COMMAND && avs_byteenable[0];
   wire rd_ok = avs_read && !avs_waitrequest;
   a_wait_once: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("wait state too long");
   a_wait_idle: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
      else $error("wait without request");
   a_rx_abort: assert property (wr_cmd && avs_writedata[2] |=> rx_abort ##1 !rx_run)
      else $error("receiver reset missed");
   a_tx_abort: assert property (wr_cmd && avs_writedata[3] |=> tx_abort)
      else $error("transmitter reset missed");
   a_abort_single: assert property (rx_abort |=> !rx_abort)
      else $error("abort pulse too long");
   a_rx_off_idle: assert property (wr_cmd && avs_writedata[5] && !rx_busy |=> ##1 !rx_run)
      else $error("idle receiver not stopped");
   a_parity_map: assert property (avs_write && !avs_waitrequest && avs_address == `DBS_OFS_SETUP && avs_byteenable[1]
      |-> ##2 parity_on == !$past(avs_writedata[11], 2)
      && (!parity_on || parity_kind == $past(avs_writedata[10:9], 2)))
      else $error("check bit decode wrong");
   a_unmapped_zero: assert property (rd_ok && (avs_address == `DBS_OFS_COMMAND || avs_address == `DBS_OFS_IRQ_SET
      || avs_address == `DBS_OFS_IRQ_CLR || avs_address > 8'h14) |-> avs_readdata == 32'h0000_0000)
      else $error("write-only or hole read not zero");
   a_setup_reserved: assert property (rd_ok && avs_address == `DBS_OFS_SETUP
      |-> (avs_readdata & ~`DBS_SETUP_MASK) == 32'h0000_0000)
      else $error("reserved setup bit set");
   a_flag_mirror: assert property (rd_ok && avs_address == `DBS_OFS_FLAGS
      |-> avs_readdata[4:3] == $past({tx_block_end, rx_block_end})
      && (avs_readdata & ~`DBS_FLAG_MASK) == 32'h0000_0000)
      else $error("flag map wrong");
endmodule
bind dbs_ctl dbs_ctl_checker #(.ADDR_W(ADDR_W)) u_chk (.clock(clock), .reset(reset), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rx_busy(rx_busy),
   .rx_block_end(rx_block_end), .tx_block_end(tx_block_end), .rx_abort(rx_abort), .tx_abort(tx_abort),
   .rx_run(rx_run), .parity_on(parity_on), .parity_kind(parity_kind));

// File: verif/dbs_ctl_far.sv
`timescale 1ns/1ps
module dbs_ctl_far (
   input wire clock,
   input wire reset,
   output logic serial_in_pin,
   output logic tx_line
);
   logic [4:0] cnt_q;
   always @(posedge clock) begin
      cnt_q <= reset ? 5'h00 : cnt_q + 5'h01;
   end
   // Held 8 cycles so the synchronised path settles before the next change
   assign serial_in_pin = cnt_q[3];
   assign tx_line = cnt_q[4];
endmodule

// File: verif/dbs_ctl_test.sv
`timescale 1ns/1ps
`include "dbs_ctl_defs.vh"
module dbs_ctl_test;
   logic clock = 0, reset = 1, avs_read = 0, avs_write = 0;
   logic [7:0] avs_address = 8'h00;
   logic [31:0] avs_writedata = 32'h0000_0000, rd_q;
   logic [12:0] eng = 13'h0000;
   wire [31:0] avs_readdata;
   wire [1:0] parity_kind;
   wire avs_waitrequest, tx_line, serial_in_pin, rx_line, serial_out_pin, rx_abort, tx_abort, rx_run, tx_run;
   wire parity_on, irq;
   int failures = 0, total_checks = 0;
   always #5 clock = ~clock;
   dbs_ctl uut (.clock(clock), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .rx_char_waiting(eng[0]), .rx_busy(eng[1]), .tx_holding_full(eng[2]),
      .tx_busy(eng[3]), .overrun_event(eng[4]), .framing_event(eng[5]), .check_bit_event(eng[6]),
      .rx_block_end(eng[7]), .tx_block_end(eng[8]), .tx_block_buf_empty(eng[9]), .rx_block_buf_full(eng[10]),
      .debug_write_pending(eng[11]), .debug_read_pending(eng[12]), .tx_line(tx_line),
      .serial_in_pin(serial_in_pin), .rx_line(rx_line), .serial_out_pin(serial_out_pin), .rx_abort(rx_abort),
      .tx_abort(tx_abort), .rx_run(rx_run), .tx_run(tx_run), .parity_on(parity_on), .parity_kind(parity_kind),
      .irq(irq));
   dbs_ctl_far far (.clock(clock), .reset(reset), .serial_in_pin(serial_in_pin), .tx_line(tx_line));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clock);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      if (n == 20) failures++;
      rd_q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic set_eng(input logic [12:0] v);
      @(posedge clock);
      eng <= v;
   endtask
   task automatic t_regs;
      bus(1, `DBS_OFS_SETUP, 32'hFFFF_FFFF);
      bus(0, `DBS_OFS_SETUP, 32'h0000_0000);
      chk(rd_q, 32'h0000_CE00);
      bus(1, `DBS_OFS_IRQ_SET, 32'hFFFF_FFFF);
      bus(0, `DBS_OFS_IRQ_VIEW, 32'h0000_0000);
      chk(rd_q, `DBS_FLAG_MASK);
      bus(1, `DBS_OFS_IRQ_CLR, 32'h0000_00FB);
      bus(0, `DBS_OFS_IRQ_VIEW, 32'h0000_0000);
      chk(rd_q, 32'hC000_1A00);
      bus(1, `DBS_OFS_IRQ_CLR, 32'hFFFF_FFFF);
      bus(0, 8'h40, 32'h0000_0000);
      chk(rd_q, 32'h0000_0000);
      for (int i = 0; i < 8; i++) begin
         bus(1, `DBS_OFS_SETUP, i << 9);
         settle(2);
         chk(parity_on, !i[2]);
         if (!i[2]) chk(parity_kind, i[1:0]);
      end
   endtask
   task automatic t_cmds;
      bus(1, `DBS_OFS_COMMAND, 32'h0000_0010);
      set_eng(13'h0001);
      bus(0, `DBS_OFS_FLAGS, 32'h0000_0000);
      chk(rd_q[0], 1'b1);
      bus(1, `DBS_OFS_COMMAND, 32'h0000_0030);
      bus(0, `DBS_OFS_FLAGS, 32'h0000_0000);
      chk({rx_run, rd_q[0]}, 2'b00);
      bus(1, `DBS_OFS_COMMAND, 32'h0000_0010);
      bus(1, `DBS_OFS_COMMAND, 32'h0000_0014);
      #1;
      chk(rx_abort, 1'b1);
      settle(1);
      chk({rx_abort, rx_run}, 2'b00);
      set_eng(13'h0008);
      bus(1, `DBS_OFS_COMMAND, 32'h0000_0040);
      bus(0, `DBS_OFS_FLAGS, 32'h0000_0000);
      chk({tx_run, rd_q[9], rd_q[1]}, 3'b101);
      bus(1, `DBS_OFS_COMMAND, 32'h0000_0080);
      settle(2);
      chk(tx_run, 1'b1);
      set_eng(13'h0000);
      settle(3);
      chk(tx_run, 1'b0);
      bus(1, `DBS_OFS_COMMAND, 32'h0000_0040);
      set_eng(13'h0004);
      bus(0, `DBS_OFS_FLAGS, 32'h0000_0000);
      chk({tx_run, rd_q[9], rd_q[1]}, 3'b100);
      bus(1, `DBS_OFS_COMMAND, 32'h0000_0008);
      #1;
      chk(tx_abort, 1'b1);
      settle(1);
      chk({tx_abort, tx_run}, 2'b00);
      set_eng(13'h0000);
   endtask
   task automatic t_errors;
      bus(1, `DBS_OFS_IRQ_SET, 32'h0000_0020);
      set_eng(13'h0010);
      set_eng(13'h0060);
      set_eng(13'h0000);
      settle(2);
      chk(irq, 1'b1);
      bus(0, `DBS_OFS_FLAGS, 32'h0000_0000);
      chk(rd_q[7:5], 3'b111);
      bus(1, `DBS_OFS_COMMAND, 32'h0000_0100);
      bus(0, `DBS_OFS_FLAGS, 32'h0000_0000);
      chk(rd_q[7:5], 3'b000);
      settle(2);
      chk(irq, 1'b0);
      set_eng(13'h1F80);
      settle(3);
      bus(0, `DBS_OFS_FLAGS, 32'h0000_0000);
      chk(rd_q & 32'hC000_1818, 32'hC000_1818);
      set_eng(13'h0000);
   endtask
   task automatic t_modes;
      // Both engines on, so the remote loopback check below can see them forced off
      bus(1, `DBS_OFS_COMMAND, 32'h0000_0050);
      for (int m = 0; m < 4; m++) begin
         bus(1, `DBS_OFS_SETUP, m << 14);
         @(serial_in_pin);
         settle(4);
         chk(serial_out_pin, m == 0 ? tx_line : m == 2 ? 1'b1 : serial_in_pin);
         chk(rx_line, m == 2 ? tx_line : m == 3 ? 1'b1 : serial_in_pin);
         chk({rx_run, tx_run}, m == 3 ? 2'b00 : 2'b11);
      end
   endtask
   task automatic tally_and_finish;
      if (failures == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge clock);
      reset <= 1'b0;
      t_regs;
      t_cmds;
      t_errors;
      t_modes;
      tally_and_finish;
   end
   initial begin
      repeat (5000) @(posedge clock);
      failures++;
      tally_and_finish;
   end
endmodule
